// ===== rtl/iac_capture.sv
`timescale 1ns/1ps
`include "iac_regs.svh"

// =====================================================================
// Capture end: latches both ports on their own output clock edge
// =====================================================================
module iac_capture (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	iac_link_if.cap LNK,
	input wire logic PHASE_ALIGN_EN,
	output iac_pkg::iac_code_t SAMPLE_WORD,
	output logic SAMPLE_VALID,
	output iac_pkg::iac_port_e SAMPLE_PORT
);
	import iac_pkg::*;

	logic clk_q;
	logic phase_toggle;
	logic drive;

	// Previous output clock level for edge detection
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= LNK.data_out_clock;
		end
	end

	// Port A on rising edge, port B on falling, giving time order A then B
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SAMPLE_WORD <= `IAC_CODE_ZERO;
			SAMPLE_VALID <= 1'b0;
			SAMPLE_PORT <= IAC_PORT_A;
		end else begin
			SAMPLE_VALID <= LNK.data_out_clock != clk_q;
			if (LNK.data_out_clock && !clk_q) begin
				SAMPLE_WORD <= LNK.port_a_word;
				SAMPLE_PORT <= IAC_PORT_A;
			end else if (!LNK.data_out_clock && clk_q) begin
				SAMPLE_WORD <= LNK.port_b_word;
				SAMPLE_PORT <= IAC_PORT_B;
			end
		end
	end

	// Half-rate phase-select signal, a one on the first cycle after enable
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_toggle <= 1'b1;
			drive <= 1'b0;
		end else begin
			drive <= PHASE_ALIGN_EN;
			phase_toggle <= drive ? ~phase_toggle : 1'b1;
		end
	end

	assign LNK.phase_select_input = phase_toggle;
	assign LNK.phase_select_drive = drive;

endmodule : iac_capture

// ===== rtl/iac_converter.sv
`timescale 1ns/1ps
`include "iac_regs.svh"

// Function
// - Differential +-125 mV gives full, mid, zero
// - Single-ended +-250 mV gives full, mid, zero
// - Input clock halved to strobe both halves
// - Port A valid on rise, B on fall
// - Normal mode output clock is half rate
// - Grounded rate pin: divide by ten, 50% duty
// - Test mode keeps one sample in five
// - Open rate pin means normal mode
// - Port phase undefined unless phase select used
// - Other side drives half-rate phase select
// - Phase select one routes sample to A
// - Phase select zero routes sample to B
// - Input clock never above 500 MHz
// - Halves feed A and B alternately
// - Sample reaches port after 15 cycles
// - Out of range saturates, never wraps
// - Port rate half or tenth of input
module iac_converter #(
	parameter int LATENCY = `IAC_LATENCY
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	iac_link_if.dev LNK,
	input iac_pkg::iac_mv_t ANALOG_IN_POS,
	input iac_pkg::iac_mv_t ANALOG_IN_NEG,
	input wire logic RATE_SELECT_DRIVEN,
	input wire logic RATE_SELECT_LEVEL
);
	import iac_pkg::*;

	// Stages ahead of the port latch; the latch itself ends the latency count
	localparam int DEPTH = LATENCY;

	// =====================================================================
	// Quantizer
	// =====================================================================

	// Offset-binary code of a voltage difference, clamped at both ends
	function automatic iac_code_t quantize(input iac_mv_t pos, input iac_mv_t neg);
		logic signed [31:0] diff;
		logic signed [31:0] level;
		diff = 32'(pos) - 32'(neg);
		level = (diff * `IAC_HALF_CODES) / `IAC_SPAN_MV + `IAC_HALF_CODES;
		// Signed limit, so a negative level is not read as a huge one
		if (level > $signed(32'(`IAC_CODE_FULL))) begin
			quantize = `IAC_CODE_FULL;
		end else if (level < 32'sh0) begin
			quantize = `IAC_CODE_ZERO;
		end else begin
			quantize = level[7:0];
		end
	endfunction : quantize

	// =====================================================================
	// Rate-select pin synchroniser
	// =====================================================================
	logic drv_s1;
	logic drv_s2;
	logic lvl_s1;
	logic lvl_s2;
	logic test_mode;

	// Two flops before any logic looks at the pin
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			drv_s1 <= 1'b0;
			drv_s2 <= 1'b0;
			lvl_s1 <= 1'b1;
			lvl_s2 <= 1'b1;
		end else begin
			drv_s1 <= RATE_SELECT_DRIVEN;
			drv_s2 <= drv_s1;
			lvl_s1 <= RATE_SELECT_LEVEL;
			lvl_s2 <= lvl_s1;
		end
	end

	// Only a pin held to ground selects test mode; an open pin stays normal
	assign test_mode = drv_s2 && !lvl_s2;

	// =====================================================================
	// Strobe divider and port routing
	// =====================================================================
	logic strobe_phase;
	iac_port_e route;
	logic [2:0] keep_cnt;
	logic keep;

	// Tracking input overrides the free-running halving toggle
	always_comb begin
		if (LNK.phase_select_drive) begin
			route = LNK.phase_select_input ? IAC_PORT_A : IAC_PORT_B;
		end else begin
			route = strobe_phase ? IAC_PORT_A : IAC_PORT_B;
		end
	end

	// Halved strobe alternates the two converter halves
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			strobe_phase <= 1'b1;
		end else begin
			strobe_phase <= (route == IAC_PORT_B);
		end
	end

	// Test mode decimation: one sample kept in every five
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			keep_cnt <= `IAC_TEST_CNT_ZERO;
		end else if (!test_mode || keep_cnt == `IAC_TEST_CNT_LAST) begin
			keep_cnt <= `IAC_TEST_CNT_ZERO;
		end else begin
			keep_cnt <= keep_cnt + 3'h1;
		end
	end

	assign keep = !test_mode || keep_cnt == `IAC_TEST_CNT_ZERO;

	// =====================================================================
	// Processing pipeline
	// =====================================================================
	iac_code_t pipe_code [DEPTH];
	iac_port_e pipe_port [DEPTH];
	logic pipe_valid [DEPTH];

	// Every input edge is sampled; dropped samples ride along as invalid
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe_code[i] <= `IAC_CODE_ZERO;
				pipe_port[i] <= IAC_PORT_A;
				pipe_valid[i] <= 1'b0;
			end
		end else begin
			pipe_code[0] <= quantize(ANALOG_IN_POS, ANALOG_IN_NEG);
			pipe_port[0] <= route;
			pipe_valid[0] <= keep;
			for (int i = 1; i < DEPTH; i++) begin
				pipe_code[i] <= pipe_code[i-1];
				pipe_port[i] <= pipe_port[i-1];
				pipe_valid[i] <= pipe_valid[i-1];
			end
		end
	end

	// =====================================================================
	// Output latches and output clock
	// =====================================================================
	iac_code_t port_a;
	iac_code_t port_b;
	logic out_clk;

	// Port latch and output clock edge move together on the last stage
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			port_a <= `IAC_CODE_MID;
			port_b <= `IAC_CODE_MID;
		end else if (pipe_valid[DEPTH-1]) begin
			if (pipe_port[DEPTH-1] == IAC_PORT_A) begin
				port_a <= pipe_code[DEPTH-1];
			end else begin
				port_b <= pipe_code[DEPTH-1];
			end
		end
	end

	// High after an A word, low after a B word: half rate, or a tenth in test
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			out_clk <= 1'b0;
		end else if (pipe_valid[DEPTH-1]) begin
			out_clk <= (pipe_port[DEPTH-1] == IAC_PORT_A);
		end
	end

	assign LNK.data_out_clock = out_clk;
	assign LNK.port_a_word = port_a;
	assign LNK.port_b_word = port_b;

endmodule : iac_converter

// ===== rtl/iac_link_if.sv
`timescale 1ns/1ps

// Output clock, both data ports and the phase-select pair between the ends
interface iac_link_if;
	logic data_out_clock;
	iac_pkg::iac_code_t port_a_word;
	iac_pkg::iac_code_t port_b_word;
	logic phase_select_input;
	logic phase_select_drive;

	modport dev (
		output data_out_clock,
		output port_a_word,
		output port_b_word,
		input phase_select_input,
		input phase_select_drive
	);

	modport cap (
		input data_out_clock,
		input port_a_word,
		input port_b_word,
		output phase_select_input,
		output phase_select_drive
	);
endinterface : iac_link_if

// ===== rtl/iac_pkg.sv
package iac_pkg;

	// =====================================================================
	// Shared types
	// =====================================================================
	typedef logic [7:0] iac_code_t;
	typedef logic signed [15:0] iac_mv_t;

	// Output port that a sample is routed to
	typedef enum logic {
		IAC_PORT_A,
		IAC_PORT_B
	} iac_port_e;

endpackage : iac_pkg

// ===== rtl/iac_regs.svh
`ifndef IAC_REGS_SVH
`define IAC_REGS_SVH

// =====================================================================
// Conversion constants
// =====================================================================
`define IAC_CODE_W 8
`define IAC_CODE_FULL 8'hFF
`define IAC_CODE_MID 8'h80
`define IAC_CODE_ZERO 8'h00
// Input span in millivolts from mid scale to full scale
`define IAC_SPAN_MV 250
// Codes from mid scale to full scale
`define IAC_HALF_CODES 128

// =====================================================================
// Timing constants, in input clock cycles
// =====================================================================
`define IAC_LATENCY 15
`define IAC_TEST_KEEP_EVERY 5
`define IAC_TEST_CNT_LAST 3'h4
`define IAC_TEST_CNT_ZERO 3'h0

`endif

// ===== tb/iac_link_assertions.sv
`timescale 1ns/1ps

// =====================================================================
// Link checker between converter and capture
// =====================================================================
module iac_link_assertions (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic data_out_clock,
	input iac_pkg::iac_code_t port_a_word,
	input iac_pkg::iac_code_t port_b_word,
	input wire logic phase_select_input,
	input wire logic phase_select_drive
);
	import iac_pkg::*;
	logic [4:0] since_rst;
	logic [4:0] since_drv;
	logic settled;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	// Edges since reset release, saturating
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			since_rst <= 5'h00;
		end else if (since_rst != 5'h1F) begin
			since_rst <= since_rst + 5'h01;
		end
	end

	// Edges since phase drive began; zero while not driven
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			since_drv <= 5'h00;
		end else if (!phase_select_drive) begin
			since_drv <= 5'h00;
		end else if (since_drv != 5'h1F) begin
			since_drv <= since_drv + 5'h01;
		end
	end

	// Skip the one-off realignment when phase drive starts
	assign settled = (since_drv == 5'h00) || (since_drv > 5'h14);

	a_a_word_high: assert property ($changed(port_a_word) |-> data_out_clock)
		else $error("port A word changed with output clock low");
	a_b_word_low: assert property ($changed(port_b_word) |-> !data_out_clock)
		else $error("port B word changed with output clock high");
	a_high_width: assert property ($rose(data_out_clock) && settled |=>
		!data_out_clock or (data_out_clock[*4] ##1 !data_out_clock))
		else $error("output clock high time wrong");
	a_low_width: assert property ($fell(data_out_clock) && settled |=>
		data_out_clock or (!data_out_clock[*4] ##1 data_out_clock))
		else $error("output clock low time wrong");
	a_first_latency: assert property (since_rst < 5'h10 |-> !data_out_clock)
		else $error("output clock moved before pipeline filled");
	a_phase_toggles: assert property (phase_select_drive && $past(phase_select_drive) |->
		$changed(phase_select_input))
		else $error("phase select did not toggle");
	a_phase_first_one: assert property ($rose(phase_select_drive) |-> phase_select_input)
		else $error("phase select did not start at one");
	a_route_to_a: assert property (phase_select_drive && phase_select_input && since_drv > 5'h14
		|-> ##16 data_out_clock)
		else $error("sample not routed to port A");
	a_route_to_b: assert property (phase_select_drive && !phase_select_input && since_drv > 5'h14
		|-> ##16 !data_out_clock)
		else $error("sample not routed to port B");

	c_phase_drive: cover property ($rose(phase_select_drive));
	c_slow_clock: cover property ($rose(data_out_clock) ##1 data_out_clock[*4]);
	c_b_update: cover property ($changed(port_b_word));
endmodule : iac_link_assertions

// ===== tb/tb.sv
`timescale 1ns/1ps

// =====================================================================
// Bench: converter facing capture across the link
// =====================================================================
module tb;
	import iac_pkg::*;
	logic core_clk;
	logic reset_n;
	iac_mv_t pos;
	iac_mv_t neg;
	logic rs_drv;
	logic rs_lvl;
	logic align_en;
	iac_code_t s_word;
	logic s_valid;
	iac_port_e s_port;
	int fail_count;
	int checks_done;
	iac_link_if lnk ();
	iac_converter iac_converter_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LNK(lnk),
		.ANALOG_IN_POS(pos), .ANALOG_IN_NEG(neg), .RATE_SELECT_DRIVEN(rs_drv),
		.RATE_SELECT_LEVEL(rs_lvl));
	iac_capture iac_capture_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .LNK(lnk),
		.PHASE_ALIGN_EN(align_en), .SAMPLE_WORD(s_word), .SAMPLE_VALID(s_valid),
		.SAMPLE_PORT(s_port));
	iac_link_assertions iac_link_assertions_i (.CORE_CLK(core_clk), .RESET_N(reset_n),
		.data_out_clock(lnk.data_out_clock), .port_a_word(lnk.port_a_word),
		.port_b_word(lnk.port_b_word), .phase_select_input(lnk.phase_select_input),
		.phase_select_drive(lnk.phase_select_drive));

	// 20 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic restart(input logic drv, input logic lvl, input logic aln);
		reset_n = 1'b0;
		rs_drv = drv;
		rs_lvl = lvl;
		align_en = aln;
		pos = '0;
		neg = '0;
		cyc(12);
		reset_n = 1'b1;
		cyc(20);
	endtask : restart

	task automatic convert(input int p, input int n, input logic [7:0] exp);
		pos = iac_mv_t'(p);
		neg = iac_mv_t'(n);
		cyc(30);
		check(lnk.port_a_word, exp);
		check(lnk.port_b_word, exp);
	endtask : convert

	task automatic latency(input int p, input logic [7:0] exp);
		int n;
		n = 0;
		pos = iac_mv_t'(p);
		while (lnk.port_a_word !== exp && lnk.port_b_word !== exp && n < 40) begin
			cyc(1);
			n++;
		end
		check(8'(n - 1), 8'h0F);
	endtask : latency

	task automatic rate(input logic [7:0] rises, input logic [7:0] valids);
		logic [7:0] r;
		logic [7:0] h;
		logic [7:0] v;
		logic last;
		r = 8'h00;
		h = 8'h00;
		v = 8'h00;
		last = lnk.data_out_clock;
		repeat (40) begin
			cyc(1);
			r = r + {7'h00, lnk.data_out_clock & ~last};
			h = h + {7'h00, lnk.data_out_clock};
			v = v + {7'h00, s_valid};
			last = lnk.data_out_clock;
		end
		check(r, rises);
		check(h, 8'h14);
		check(v, valids);
	endtask : rate

	// Rising ramp: captured words must come back in time order
	task automatic ramp();
		logic [7:0] last;
		iac_port_e lp;
		logic have;
		have = 1'b0;
		neg = '0;
		for (int i = 0; i < 40; i++) begin
			pos = iac_mv_t'(2 * i);
			cyc(1);
			if (s_valid === 1'b1) begin
				if (have && s_word > 8'h80) begin
					check(s_word, last + 8'h01);
					check({7'h00, s_port}, {7'h00, ~lp});
				end
				have = 1'b1;
				last = s_word;
				lp = s_port;
			end
		end
	endtask : ramp

	task automatic end_of_test();
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		fail_count = 0;
		checks_done = 0;
		restart(1'b0, 1'b0, 1'b0);
		convert(125, -125, 8'hFF);
		convert(0, 0, 8'h80);
		convert(-125, 125, 8'h00);
		convert(250, 0, 8'hFF);
		convert(-250, 0, 8'h00);
		latency(250, 8'hFF);
		convert(125, 0, 8'hC0);
		convert(900, -900, 8'hFF);
		convert(-900, 900, 8'h00);
		rate(8'h14, 8'h28);
		ramp();
		restart(1'b1, 1'b0, 1'b0);
		rate(8'h04, 8'h08);
		convert(-250, 0, 8'h00);
		restart(1'b1, 1'b1, 1'b0);
		rate(8'h14, 8'h28);
		restart(1'b0, 1'b0, 1'b1);
		cyc(30);
		ramp();
		end_of_test();
	end
endmodule : tb
